// [rtl/tfp_port_timing.sv]
// Frame and bit timing of the time-division subscriber port.
//
// Operation
// - Rising frame_sync starts frame; edge chosen by bit.
// - Reference clock divides source by 2, 1.5, 1.
// - Port layout selects logical port count and rate.
// - Alternate input choice routes receive pins; unused tristate.
// - Framing code selects frame_sync output pulse type.
// - Output clock runs at rate, or twice it in the quad and octal layouts only.
// - Transmit edge chosen by tx_falling_edge.
// - Receive edge chosen by rx_rising_edge.
// - Frame length is frame_bit_count plus one.
// - Framing signal marks slot slot_adjust minus two.
// - Internal source: offsets shift frame and frame_sync together.
// - External source: offsets shift frame against incoming frame_sync.
// - Common shift places frame start for both directions.
// - Upstream frame lags downstream by zero to fifteen.
// - Source select picks internal PCM timing or pins.
`timescale 1ns/1ps
module tfp_port_timing (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Register port.
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // PCM side timing source.
  input  wire logic       pcm_data_clock,
  input  wire logic       pcm_frame_sync,
  // Data clock pin.
  input  wire logic       data_clock_line_in,
  output logic            data_clock_line_out,
  output logic            data_clock_line_oe,
  // Frame sync pin.
  input  wire logic       frame_sync_in,
  output logic            frame_sync_out,
  output logic            frame_sync_oe,
  // Physical receive pins.
  input  wire logic [7:0] subscriber_port_in,
  // Transmit data per logical port and drive enables per physical pin.
  input  wire logic [7:0] tx_data,
  output logic      [7:0] subscriber_port_out,
  output logic      [7:0] subscriber_port_oe,
  // Received bits per logical port.
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  // Frame position and status.
  output logic      [9:0] down_bit_pos,
  output logic      [9:0] up_bit_pos,
  output logic            frame_start,
  output logic            config_error
);

  // Register storage.
  logic [7:0] port_mode_ctl_1;
  logic [7:0] port_mode_ctl_2;
  logic [7:0] frame_length_low;
  logic [7:0] slot_adjust_reg;
  logic [7:0] bit_shift_reg;
  logic [7:0] next_mode_1, next_mode_2, next_flow, next_slot, next_shift;

  // Decoded fields.
  logic       clock_source_sel;
  logic       frame_sync_edge_sel;
  logic [1:0] source_prescale;
  logic [1:0] port_mode_sel;
  logic [1:0] alt_input_sel;
  logic [2:0] framing_out_ctl;
  logic       out_clock_double;
  logic       tx_falling_edge;
  logic       rx_rising_edge;
  logic [9:0] frame_bit_count;
  logic [6:0] slot_adjust;
  logic [2:0] common_bit_shift;
  logic [3:0] upstream_bit_shift;

  assign clock_source_sel    = port_mode_ctl_1[tfp_pkg::POS_CLK_SRC];
  assign frame_sync_edge_sel = port_mode_ctl_1[tfp_pkg::POS_SYNC_EDGE];
  assign source_prescale     = port_mode_ctl_1[tfp_pkg::POS_PRESC +: 2];
  assign port_mode_sel       = port_mode_ctl_1[tfp_pkg::POS_PMODE +: 2];
  assign alt_input_sel       = port_mode_ctl_1[tfp_pkg::POS_ALT_IN +: 2];
  assign framing_out_ctl     = port_mode_ctl_2[tfp_pkg::POS_FRAMING +: 3];
  assign out_clock_double    = port_mode_ctl_2[tfp_pkg::POS_CLK_DBL];
  assign tx_falling_edge     = port_mode_ctl_2[tfp_pkg::POS_TX_FALL];
  assign rx_rising_edge      = port_mode_ctl_2[tfp_pkg::POS_RX_RISE];
  assign slot_adjust         = slot_adjust_reg[6:0];
  assign common_bit_shift    = bit_shift_reg[tfp_pkg::POS_CMN_SHIFT +: 3];
  assign upstream_bit_shift  = bit_shift_reg[tfp_pkg::POS_UP_SHIFT +: 4];
  // The two upper bits live in the second mode register.
  assign frame_bit_count = {port_mode_ctl_2[tfp_pkg::POS_FBC_HIGH +: 2], frame_length_low};

  // Address match, used by both the write and the read path.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // Compute register next values from writes; bit 7 of the slot and shift registers is fixed zero.
  always_comb begin
    next_mode_1 = port_mode_ctl_1;
    next_mode_2 = port_mode_ctl_2;
    next_flow   = frame_length_low;
    next_slot   = slot_adjust_reg;
    next_shift  = bit_shift_reg;
    if (reg_wr) begin
      if (hit(reg_addr, tfp_pkg::OFS_MODE_CTL_1)) begin
        next_mode_1 = reg_wdata;
      end
      if (hit(reg_addr, tfp_pkg::OFS_MODE_CTL_2)) begin
        next_mode_2 = reg_wdata;
      end
      if (hit(reg_addr, tfp_pkg::OFS_FRAME_LOW)) begin
        next_flow = reg_wdata;
      end
      if (hit(reg_addr, tfp_pkg::OFS_SLOT_ADJ)) begin
        next_slot = {1'b0, reg_wdata[6:0]};
      end
      if (hit(reg_addr, tfp_pkg::OFS_BIT_SHIFT)) begin
        next_shift = {1'b0, reg_wdata[6:0]};
      end
    end
  end

  // Register storage; read data is registered one cycle after the read strobe.
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, tfp_pkg::OFS_MODE_CTL_1)) next_rdata = port_mode_ctl_1;
      if (hit(reg_addr, tfp_pkg::OFS_MODE_CTL_2)) next_rdata = port_mode_ctl_2;
      if (hit(reg_addr, tfp_pkg::OFS_FRAME_LOW))  next_rdata = frame_length_low;
      if (hit(reg_addr, tfp_pkg::OFS_SLOT_ADJ))   next_rdata = slot_adjust_reg;
      if (hit(reg_addr, tfp_pkg::OFS_BIT_SHIFT))  next_rdata = bit_shift_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_mode_ctl_1  <= tfp_pkg::RST_MODE_CTL_1;
      port_mode_ctl_2  <= tfp_pkg::RST_MODE_CTL_2;
      frame_length_low <= tfp_pkg::RST_FRAME_LOW;
      slot_adjust_reg  <= tfp_pkg::RST_SLOT_ADJ;
      bit_shift_reg    <= tfp_pkg::RST_BIT_SHIFT;
      reg_rdata        <= 8'h00;
    end else begin
      port_mode_ctl_1  <= next_mode_1;
      port_mode_ctl_2  <= next_mode_2;
      frame_length_low <= next_flow;
      slot_adjust_reg  <= next_slot;
      bit_shift_reg    <= next_shift;
      reg_rdata        <= next_rdata;
    end
  end

  // Synchronised pins; source clock and framing come from PCM side or pins.
  logic pdc_rise, pdc_fall;
  logic dcl_rise, dcl_fall, fsi_lvl;
  logic pfs_lvl;
  logic [7:0] rx_pin_s1, rx_pin_s2;

  tfp_sync_edge u_pdc (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(pcm_data_clock),
                       .level(), .rise(pdc_rise), .fall(pdc_fall));
  tfp_sync_edge u_pfs (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(pcm_frame_sync),
                       .level(pfs_lvl), .rise(), .fall());
  tfp_sync_edge u_dcl (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(data_clock_line_in),
                       .level(), .rise(dcl_rise), .fall(dcl_fall));

  // Frame sync pin and receive pins pass two flops; pin level is sampled on a clock edge.
  logic fsi_s1;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fsi_s1    <= 1'b0;
      fsi_lvl   <= 1'b0;
      rx_pin_s1 <= 8'h00;
      rx_pin_s2 <= 8'h00;
    end else begin
      fsi_s1    <= frame_sync_in;
      fsi_lvl   <= fsi_s1;
      rx_pin_s1 <= subscriber_port_in;
      rx_pin_s2 <= rx_pin_s1;
    end
  end

  // Selected source edges.
  logic src_rise, src_fall, src_edge;
  assign src_rise = clock_source_sel ? dcl_rise : pdc_rise;
  assign src_fall = clock_source_sel ? dcl_fall : pdc_fall;
  assign src_edge = src_rise | src_fall;

  // Prescaler: divide 2 keeps every second edge, 1.5 keeps two of three, 1 keeps all.
  // A reference edge toggles a phase; even phase is rising, odd is falling.
  logic [1:0] psc_cnt, next_psc_cnt;
  logic       ref_rise, ref_fall, ref_phase, next_ref_phase, ref_evt;
  always_comb begin
    next_psc_cnt   = psc_cnt;
    ref_evt        = 1'b0;
    next_ref_phase = ref_phase;
    if (src_edge) begin
      case (source_prescale)
        tfp_pkg::PRESC_DIV2: begin
          next_psc_cnt = {1'b0, ~psc_cnt[0]};
          ref_evt      = psc_cnt[0];
        end
        tfp_pkg::PRESC_DIV15: begin
          next_psc_cnt = (psc_cnt == 2'h2) ? 2'h0 : psc_cnt + 2'h1;
          ref_evt      = (psc_cnt != 2'h2);
        end
        tfp_pkg::PRESC_DIV1: begin
          ref_evt = 1'b1;
        end
        default: begin
          ref_evt = 1'b0; // The forbidden code stops the reference clock.
        end
      endcase
      if (ref_evt) begin
        next_ref_phase = ~ref_phase;
      end
    end
  end
  assign ref_rise = ref_evt & ~ref_phase;
  assign ref_fall = ref_evt & ref_phase;

  // Reference edges per port bit depends on the port layout.
  logic [2:0] ref_per_bit;
  always_comb begin
    case (port_mode_sel)
      tfp_pkg::PMODE_QUAD_DU: ref_per_bit = tfp_pkg::REF_PER_BIT_M0;
      tfp_pkg::PMODE_DUAL_DU: ref_per_bit = tfp_pkg::REF_PER_BIT_M1;
      tfp_pkg::PMODE_ONE_DU:  ref_per_bit = tfp_pkg::REF_PER_BIT_M1;
      default:                ref_per_bit = tfp_pkg::REF_PER_BIT_M3;
    endcase
  end

  // Frame sync sampled on chosen data-clock edge; rising level starts the frame.
  logic fs_src, fs_samp, next_fs_samp, sync_edge, fs_start;
  assign fs_src    = clock_source_sel ? fsi_lvl : pfs_lvl;
  assign sync_edge = frame_sync_edge_sel ? src_rise : src_fall;
  assign next_fs_samp = sync_edge ? fs_src : fs_samp;
  assign fs_start  = sync_edge & fs_src & ~fs_samp;

  // Reload position: slot (slot_adjust - 2) at the common shift bit.
  // Shift code 2 is bit 7 of slot TSN; lower codes step into slot TSN-1.
  logic [9:0] reload_pos;
  always_comb begin
    reload_pos = 10'((slot_adjust - tfp_pkg::SLOT_BIAS) * tfp_pkg::BITS_PER_SLOT)
               + 10'(common_bit_shift) - 10'(tfp_pkg::SHIFT_ZERO);
    if (reload_pos > frame_bit_count) begin
      reload_pos = reload_pos + frame_bit_count + 10'h1; // Wrap into the frame.
    end
  end

  // Downstream bit counter over frame_bit_count + 1 bits, timed by reference edges.
  logic [9:0] down_pos, next_down_pos;
  logic [2:0] sub_cnt, next_sub_cnt;
  logic       bit_tick;
  assign bit_tick = ref_rise & (sub_cnt == ref_per_bit - 3'h1);
  always_comb begin
    next_down_pos = down_pos;
    next_sub_cnt  = sub_cnt;
    if (fs_start) begin
      next_down_pos = reload_pos;
      next_sub_cnt  = 3'h0;
    end else if (ref_rise) begin
      next_sub_cnt = bit_tick ? 3'h0 : sub_cnt + 3'h1;
      if (bit_tick) begin
        next_down_pos = (down_pos >= frame_bit_count) ? 10'h0 : down_pos + 10'h1;
      end
    end
  end

  // Upstream position lags downstream by upstream_bit_shift bits.
  always_comb begin
    if (down_pos >= 10'(upstream_bit_shift)) begin
      up_bit_pos = down_pos - 10'(upstream_bit_shift);
    end else begin
      up_bit_pos = down_pos + frame_bit_count + 10'h1 - 10'(upstream_bit_shift);
    end
  end
  assign down_bit_pos = down_pos;

  // Data launch and capture edges.
  logic tx_evt, rx_evt;
  assign tx_evt = tx_falling_edge ? ref_fall : ref_rise;
  assign rx_evt = rx_rising_edge ? ref_rise : ref_fall;

  // Logical to physical routing of receive pins and transmit drive.
  logic [7:0] rx_route, tx_oe_map;
  always_comb begin
    rx_route  = rx_pin_s2;
    tx_oe_map = 8'h0f;
    case (port_mode_sel)
      tfp_pkg::PMODE_DUAL_DU: begin
        rx_route[0] = alt_input_sel[0] ? 1'b0 : rx_pin_s2[0];
        rx_route[2] = alt_input_sel[0] ? rx_pin_s2[0] : 1'b0;
        rx_route[1] = alt_input_sel[1] ? 1'b0 : rx_pin_s2[1];
        rx_route[3] = alt_input_sel[1] ? rx_pin_s2[1] : 1'b0;
        tx_oe_map   = 8'h03;
      end
      tfp_pkg::PMODE_ONE_DU: begin
        rx_route    = 8'h00;
        rx_route[0] = alt_input_sel[0] ? 1'b0 : rx_pin_s2[0];
        rx_route[2] = alt_input_sel[0] ? rx_pin_s2[0] : 1'b0;
        tx_oe_map   = 8'h01;
      end
      tfp_pkg::PMODE_OCT_BI: begin
        tx_oe_map = 8'hff; // Bidirectional pins; software times direction.
      end
      default: begin
        tx_oe_map = 8'h0f;
      end
    endcase
  end

  // Frame sync output pulse by framing code; widths beyond one bit are a simple choice.
  logic fs_pulse;
  always_comb begin
    case (framing_out_ctl)
      tfp_pkg::FC_MODE0: fs_pulse = (down_pos == frame_bit_count);
      tfp_pkg::FC_MODE1: fs_pulse = (down_pos == 10'h0);
      tfp_pkg::FC_MODE2: fs_pulse = (down_pos < 10'h8);
      tfp_pkg::FC_MODE3: fs_pulse = (down_pos < 10'h2);
      tfp_pkg::FC_MODE4: fs_pulse = (down_pos < 10'h10);
      tfp_pkg::FC_MODE6: fs_pulse = (down_pos <= (frame_bit_count >> 1));
      tfp_pkg::FC_MODE7: fs_pulse = 1'b0;
      default:           fs_pulse = 1'b0; // Reserved code.
    endcase
  end

  // Output clock: data rate, or twice it where allowed, following the reference phase.
  logic dcl_q, next_dcl_q, dbl_ok, dcl_low;
  assign dbl_ok = out_clock_double & ((port_mode_sel == tfp_pkg::PMODE_QUAD_DU) |
                  (port_mode_sel == tfp_pkg::PMODE_OCT_BI));
  // Mid-bit fall point of the output clock.
  assign dcl_low = (ref_per_bit == 3'h1) ? ref_fall :
                   (ref_rise & (sub_cnt == (ref_per_bit >> 1) - 3'h1));
  always_comb begin
    next_dcl_q = dcl_q;
    if (bit_tick) begin
      next_dcl_q = 1'b1;
    end else if (dbl_ok) begin
      next_dcl_q = dcl_q ^ ((ref_per_bit == 3'h2) ? ref_evt : ref_rise);
    end else if (dcl_low) begin
      next_dcl_q = 1'b0;
    end
  end

  // Data path and output registers.
  logic [7:0] next_out, next_rx;
  assign next_out = tx_evt ? tx_data : subscriber_port_out;
  assign next_rx  = rx_evt ? rx_route : rx_data;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      psc_cnt             <= 2'h0;
      ref_phase           <= 1'b0;
      sub_cnt             <= 3'h0;
      down_pos            <= 10'h0;
      fs_samp             <= 1'b0;
      dcl_q               <= 1'b0;
      subscriber_port_out <= 8'h00;
      subscriber_port_oe  <= 8'h00;
      rx_data             <= 8'h00;
      rx_valid            <= 1'b0;
      frame_sync_out      <= 1'b0;
      frame_start         <= 1'b0;
      config_error        <= 1'b0;
    end else begin
      psc_cnt             <= next_psc_cnt;
      ref_phase           <= next_ref_phase;
      sub_cnt             <= next_sub_cnt;
      down_pos            <= next_down_pos;
      fs_samp             <= next_fs_samp;
      dcl_q               <= next_dcl_q;
      subscriber_port_out <= next_out;
      subscriber_port_oe  <= tx_oe_map;
      rx_data             <= next_rx;
      rx_valid            <= rx_evt;
      frame_sync_out      <= fs_pulse;
      frame_start         <= fs_start;
      config_error        <= (source_prescale == 2'h3) | (framing_out_ctl == tfp_pkg::FC_RESERVED);
    end
  end

  // Clock and frame sync pins are driven only when the timing comes from the PCM side.
  assign data_clock_line_out = dcl_q;
  assign data_clock_line_oe  = ~clock_source_sel;
  assign frame_sync_oe       = ~clock_source_sel;

endmodule

// [rtl/tfp_pkg.sv]
// Package with register map, field positions, reset values and mode codes of the port timing block.
package tfp_pkg;

  // Register offsets on the documented register port.
  localparam logic [3:0] OFS_MODE_CTL_1 = 4'h6;
  localparam logic [3:0] OFS_MODE_CTL_2 = 4'h7;
  localparam logic [3:0] OFS_FRAME_LOW  = 4'h8;
  localparam logic [3:0] OFS_SLOT_ADJ   = 4'h9;
  localparam logic [3:0] OFS_BIT_SHIFT  = 4'ha;

  // Reset values.
  localparam logic [7:0] RST_MODE_CTL_1 = 8'h00;
  localparam logic [7:0] RST_MODE_CTL_2 = 8'h00;
  localparam logic [7:0] RST_FRAME_LOW  = 8'hff;
  localparam logic [7:0] RST_SLOT_ADJ   = 8'h00;
  localparam logic [7:0] RST_BIT_SHIFT  = 8'h00;

  // Field positions in port_mode_ctl_1.
  localparam int POS_CLK_SRC   = 7;
  localparam int POS_SYNC_EDGE = 6;
  localparam int POS_PRESC     = 4;
  localparam int POS_PMODE     = 2;
  localparam int POS_ALT_IN    = 0;

  // Field positions in port_mode_ctl_2.
  localparam int POS_FRAMING   = 5;
  localparam int POS_CLK_DBL   = 4;
  localparam int POS_TX_FALL   = 3;
  localparam int POS_RX_RISE   = 2;
  localparam int POS_FBC_HIGH  = 0;

  // Field positions in bit_shift_reg.
  localparam int POS_CMN_SHIFT = 4;
  localparam int POS_UP_SHIFT  = 0;

  // Prescaler codes for the reference clock.
  localparam logic [1:0] PRESC_DIV2  = 2'h0;
  localparam logic [1:0] PRESC_DIV15 = 2'h1;
  localparam logic [1:0] PRESC_DIV1  = 2'h2;

  // Port layouts.
  localparam logic [1:0] PMODE_QUAD_DU = 2'h0;
  localparam logic [1:0] PMODE_DUAL_DU = 2'h1;
  localparam logic [1:0] PMODE_ONE_DU  = 2'h2;
  localparam logic [1:0] PMODE_OCT_BI  = 2'h3;

  // Framing output codes.
  localparam logic [2:0] FC_MODE0    = 3'h0;
  localparam logic [2:0] FC_MODE1    = 3'h1;
  localparam logic [2:0] FC_MODE2    = 3'h2;
  localparam logic [2:0] FC_MODE3    = 3'h3;
  localparam logic [2:0] FC_MODE4    = 3'h4;
  localparam logic [2:0] FC_RESERVED = 3'h5;
  localparam logic [2:0] FC_MODE6    = 3'h6;
  localparam logic [2:0] FC_MODE7    = 3'h7;

  // Slot adjust carries two slots of bias, and the zero bit shift is code 2.
  localparam logic [6:0] SLOT_BIAS  = 7'h02;
  localparam logic [2:0] SHIFT_ZERO = 3'h2;

  // Bits per slot and the width of the frame bit counter.
  localparam int BITS_PER_SLOT = 8;
  localparam int FBC_W         = 10;

  // Reference clock edge events per port bit, indexed by port layout (2x, 1x, 1x, 4x).
  localparam logic [2:0] REF_PER_BIT_M0 = 3'h2;
  localparam logic [2:0] REF_PER_BIT_M1 = 3'h1;
  localparam logic [2:0] REF_PER_BIT_M3 = 3'h4;

endpackage

// [rtl/tfp_sync_edge.sv]
// Two flip-flop synchroniser with rising and falling edge pulses behind it.
`timescale 1ns/1ps
module tfp_sync_edge (
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Asynchronous input level.
  input  wire logic async_in,
  // Synchronised level and edge pulses.
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic       meta;        // First stage, read only by the second stage.
  logic       stage2;      // Second stage, safe to use.
  logic       stage3;      // Delayed copy for edge detection.
  logic [2:0] next_chain;  // Next values of the three stages.

  // Shift the input through the chain.
  always_comb begin
    next_chain = {stage2, meta, async_in};
  end

  // Register the chain.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta   <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      meta   <= next_chain[0];
      stage2 <= next_chain[1];
      stage3 <= next_chain[2];
    end
  end

  // Edges are taken only between the settled stages.
  assign level = stage2;
  assign rise  = stage2 & ~stage3;
  assign fall  = ~stage2 & stage3;

endmodule

// [sim/tfp_checker.sv]
// Checker of the port timing block, bound to its top ports.
`timescale 1ns/1ps
module tfp_checker (
  // Clock and reset.
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Pin enables, positions and status.
  input wire logic       data_clock_line_oe,
  input wire logic       frame_sync_oe,
  input wire logic [7:0] subscriber_port_oe,
  input wire logic       rx_valid,
  input wire logic [9:0] down_bit_pos,
  input wire logic [9:0] up_bit_pos,
  input wire logic       config_error
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  localparam logic [7:0] OE_TBL [4] = '{8'h0f, 8'h03, 8'h01, 8'hff}; // Enables per layout.
  logic [7:0] m1, m2, bs, next_m1, next_m2, next_bs; // Shadows of the configuration.
  logic [1:0] quiet, next_quiet; // Bit 1 is set two edges after the last write.
  // Mirror writes; pin enables, error flag and lag are judged only once a write has had time to settle.
  always_comb begin
    next_m1    = (reg_wr && reg_addr == tfp_pkg::OFS_MODE_CTL_1) ? reg_wdata : m1;
    next_m2    = (reg_wr && reg_addr == tfp_pkg::OFS_MODE_CTL_2) ? reg_wdata : m2;
    next_bs    = (reg_wr && reg_addr == tfp_pkg::OFS_BIT_SHIFT) ? reg_wdata : bs;
    next_quiet = reg_wr ? 2'h0 : (quiet | {quiet[0], 1'b1});
  end
  // Register the shadows; reset restores the documented values.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      m1    <= 8'h00;
      m2    <= 8'h00;
      bs    <= 8'h00;
      quiet <= 2'h0;
    end else begin
      m1    <= next_m1;
      m2    <= next_m2;
      bs    <= next_bs;
      quiet <= next_quiet;
    end
  end
  property p_slot_msb;
    reg_rd && reg_addr == tfp_pkg::OFS_SLOT_ADJ |=> reg_rdata[7] == 1'b0;
  endproperty
  a_slot_msb: assert property (p_slot_msb) else $error("slot adjust msb read as one");
  property p_shift_msb;
    reg_rd && reg_addr == tfp_pkg::OFS_BIT_SHIFT |=> reg_rdata[7] == 1'b0;
  endproperty
  a_shift_msb: assert property (p_shift_msb) else $error("bit shift msb read as one");
  property p_dcl_oe;
    quiet[1] |-> data_clock_line_oe == !m1[tfp_pkg::POS_CLK_SRC];
  endproperty
  a_dcl_oe: assert property (p_dcl_oe) else $error("clock pin enable wrong");
  property p_fs_oe;
    quiet[1] && $stable(m1) |-> frame_sync_oe == !m1[tfp_pkg::POS_CLK_SRC];
  endproperty
  a_fs_oe: assert property (p_fs_oe) else $error("frame sync pin enable wrong");
  property p_port_oe;
    quiet[1] |-> subscriber_port_oe == OE_TBL[m1[3:2]];
  endproperty
  a_port_oe: assert property (p_port_oe) else $error("port enables wrong for layout");
  property p_cfg_err;
    quiet[1] |-> config_error == (m1[5:4] == 2'h3 || m2[7:5] == tfp_pkg::FC_RESERVED);
  endproperty
  a_cfg_err: assert property (p_cfg_err) else $error("config error flag wrong");
  property p_up_down;
    quiet[1] && bs[3:0] == 4'h0 |-> up_bit_pos == down_bit_pos;
  endproperty
  a_up_down: assert property (p_up_down) else $error("zero lag not aligned");
  property p_rx_pulse;
    $rose(rx_valid) |=> $fell(rx_valid);
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("capture pulse too long");
  c_rx: cover property (rx_valid);
  c_ext: cover property (quiet[1] && m1[7]);
  c_err: cover property (config_error);
endmodule

// [sim/tfp_partner.sv]
// Behavioural transceivers: free running bus clock, frame pulse and receive data.
`timescale 1ns/1ps
module tfp_partner #(
  parameter int HALF_NS = 37, // Half bit period, unrelated to the block clock.
  parameter int BITS    = 16  // Bits per frame.
) (
  // Lines toward the block.
  output logic       bus_clk,
  output logic       bus_fs,
  output logic [7:0] bus_data
);
  int bit_no; // Bit within the frame.
  // Lines change at the rising edge so a falling-edge sampler sees them settled.
  initial begin
    bus_clk  = 1'b0;
    bus_fs   = 1'b0;
    bus_data = 8'h00;
    bit_no   = 0;
    forever begin
      #(HALF_NS);
      bus_clk  = 1'b1;
      bus_fs   = (bit_no == 0);
      bus_data = 8'($urandom);
      bit_no   = (bit_no + 1) % BITS;
      #(HALF_NS);
      bus_clk  = 1'b0;
    end
  end
endmodule

// [sim/testbench.sv]
// Self-checking bench of the port timing block with the transceivers on its pins.
`timescale 1ns/1ps
`define CHECK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] reg_rdata, subscriber_port_out, subscriber_port_oe, rx_data, p_data;
  logic       data_clock_line_in, data_clock_line_out, data_clock_line_oe;
  logic       frame_sync_in, frame_sync_out, frame_sync_oe, p_clk, p_fs;
  logic       rx_valid, frame_start, config_error;
  logic [9:0] down_bit_pos, up_bit_pos, max_pos, pd;
  int         num_errors = 0;
  int         checks_done = 0;
  int         n_fs, n_rx, n_dcl, n_dcl0;
  logic       mon = 1'b0;
  logic [3:0] up_lag = 4'h0;
  logic [7:0] shadow [16];
  localparam logic [7:0] OE_TBL [4] = '{8'h0f, 8'h03, 8'h01, 8'hff}; // Enables per layout.
  // A pin carries the block while it drives, the transceivers otherwise.
  assign data_clock_line_in = data_clock_line_oe ? data_clock_line_out : p_clk;
  assign frame_sync_in      = frame_sync_oe ? frame_sync_out : p_fs;
  always #5 ref_clk = ~ref_clk;
  tfp_partner tfp_partner_i (.bus_clk(p_clk), .bus_fs(p_fs), .bus_data(p_data));
  tfp_port_timing tfp_port_timing_i (.pcm_data_clock(p_clk), .pcm_frame_sync(p_fs),
    .subscriber_port_in(p_data), .*);
  // Random transmit bits, changed just after each edge.
  always @(posedge ref_clk) #1 tx_data = 8'($urandom);
  // Count pulses and compare lag and framing pulse at the falling edge, where outputs settled.
  always @(negedge ref_clk) begin
    if (mon) begin
      n_fs += frame_start;
      n_rx += rx_valid;
      if (down_bit_pos > max_pos) max_pos = down_bit_pos;
      `CHECK(up_bit_pos, 10'((down_bit_pos + 16 - up_lag) % 16))
      `CHECK(frame_sync_out, pd == 10'h00f)
    end
    pd = down_bit_pos;
  end
  always @(data_clock_line_out) if (mon) n_dcl++;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk); // An idle edge keeps a strobe from falling and rising at once.
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  // Configure, wait for a frame start, then watch for a fixed span.
  task automatic run(input logic [7:0] m1, input logic [7:0] m2);
    int i;
    wr(tfp_pkg::OFS_MODE_CTL_1, m1);
    wr(tfp_pkg::OFS_MODE_CTL_2, m2);
    i = 0;
    while (frame_start !== 1'b1 && i < 3000) begin
      @(posedge ref_clk);
      #1 i++;
    end
    {n_fs, n_rx, n_dcl, max_pos} = '0;
    mon = 1'b1;
    repeat (1200) @(posedge ref_clk);
    #1 mon = 1'b0;
    `CHECK(n_fs > 0, 1'b1)
  endtask
  function automatic logic [7:0] rst_val(input logic [3:0] a);
    return (a == tfp_pkg::OFS_FRAME_LOW) ? tfp_pkg::RST_FRAME_LOW : 8'h00;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // The tests need under 10000 cycles, so 40000 marks a hang.
  initial begin
    #400us;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] v;
    void'($urandom(90666));
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    // Reset values everywhere; unmapped places read zero.
    for (int i = 0; i < 16; i++) begin
      shadow[i] = rst_val(4'(i));
      rd(4'(i), d);
      `CHECK(d, shadow[i])
    end
    $display("test reset values done");
    // Random writes and read-back; the top bit of two registers stays zero.
    for (int i = 0; i < 60; i++) begin
      a = 4'($urandom_range(15));
      v = 8'($urandom);
      wr(a, v);
      if (a >= 4'h6 && a <= 4'ha) shadow[a] = (a >= 4'h9) ? (v & 8'h7f) : v;
      rd(a, d);
      `CHECK(d, shadow[a])
    end
    $display("test register access done");
    // Every source, prescale, layout and framing code.
    for (int c = 0; c < 256; c++) begin
      wr(tfp_pkg::OFS_MODE_CTL_1, {c[7], 1'b0, c[6:3], 2'b00});
      wr(tfp_pkg::OFS_MODE_CTL_2, {c[2:0], 5'h00});
      repeat (3) @(posedge ref_clk);
      #1;
      `CHECK(subscriber_port_oe, OE_TBL[c[4:3]])
      `CHECK(config_error, c[6:5] == 2'h3 || c[2:0] == tfp_pkg::FC_RESERVED)
      `CHECK(frame_sync_oe, !c[7])
    end
    $display("test layouts done");
    // External timing, one bit per source period, sixteen-bit frames, random lag.
    wr(tfp_pkg::OFS_FRAME_LOW, 8'h0f);
    wr(tfp_pkg::OFS_SLOT_ADJ, 8'h02);
    up_lag = 4'($urandom_range(15, 1));
    wr(tfp_pkg::OFS_BIT_SHIFT, {4'h2, up_lag});
    run(8'ha4, 8'h00);
    `CHECK(max_pos, 10'h00f)
    `CHECK(n_rx > 0, 1'b1)
    // Internal timing: the output clock doubles with the rate bit.
    up_lag = 4'h0;
    wr(tfp_pkg::OFS_BIT_SHIFT, 8'h20);
    run(8'h20, 8'h00);
    n_dcl0 = n_dcl;
    run(8'h20, 8'h10);
    `CHECK(n_dcl >= 2 * n_dcl0 - 4 && n_dcl <= 2 * n_dcl0 + 4, 1'b1)
    $display("test traffic done");
    tally_and_finish();
  end
endmodule
bind tfp_port_timing tfp_checker tfp_checker_i (.*);
